// ===== rpbk_far_end.sv
// Far-end repeater model on the fast backplane
`timescale 1ns/1ns
`default_nettype none
module rpbk_far_end (
    output logic o_clk,
    output logic [4:0] o_data,
    output logic o_valid_n_oe
);
    // Clock idles high on its pull-up; data starts at 0x0A with valid released
    initial begin
        o_clk = 1'b1;
        o_data = 5'h0A;
        o_valid_n_oe = 1'b0;
    end
    // Data changes in the low phase, 16 ns before the rise, so the sample window is kept
    task automatic send(input int n, input logic [4:0] base, input bit drv);
        // Step off the core clock edge the caller may stand on
        #2;
        for (int k = 0; k < n; k++) begin
            o_clk = 1'b0;
            #16;
            o_data = base + 5'(k);
            o_valid_n_oe = drv;
            #16;
            o_clk = 1'b1;
            #32;
        end
        o_clk = 1'b0;
        #16;
        o_valid_n_oe = 1'b0;
        o_data = ~o_data; // Released bus must not keep its last value
        #16;
        o_clk = 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== rpbk_fifo.v
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module rpbk_fifo #(
    parameter WIDTH = 5,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_clk,
    input wire i_srst,
    input wire i_ce,
    input wire [WIDTH-1:0] i_data,
    input wire i_valid,
    output wire o_ready,
    output wire [WIDTH-1:0] o_data,
    output wire o_valid,
    input wire i_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;

    // Honest flags from the occupancy count
    assign o_ready = (count != DEPTH[AW:0]);
    assign o_valid = (count != {(AW+1){1'b0}});
    assign o_data = mem[rd_ptr];
    assign do_wr = i_valid && o_ready;
    assign do_rd = i_ready && o_valid;

    // Pointers wrap at the depth, which need not be a power of two
    always @(posedge i_clk) begin
        if (i_srst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else if (i_ce) begin
            if (do_wr) begin
                mem[wr_ptr] <= i_data;
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                          wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                          rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== rpbk_regs.vh
// Constants for the repeater backplane and MII port block
`ifndef RPBK_REGS_VH
`define RPBK_REGS_VH
`define RPBK_SYM_W 5
`define RPBK_NIB_W 4
`define RPBK_FIFO_DEPTH 16
`define RPBK_PRE_NIBBLES 4'hE
`define RPBK_PRE_NIB 4'h5
`define RPBK_SFD_LO 4'h5
`define RPBK_SFD_HI 4'hD
`define RPBK_SYNC_W 11
`define RPBK_SPEED_100 1'b1
`define RPBK_ST_IDLE 2'h0
`define RPBK_ST_PRE 2'h1
`define RPBK_ST_SFD 2'h2
`define RPBK_ST_DATA 2'h3
`endif

// ===== rpbk_top.v
// Repeater backplane ends and MII transmit path
`timescale 1ns/1ns
`default_nettype none
`include "rpbk_regs.vh"
module rpbk_top #(
    parameter FIFO_DEPTH = `RPBK_FIFO_DEPTH,
    parameter FIFO_AW = 4
) (
    input wire i_clk,
    input wire i_srst,
    input wire i_ce,
    input wire i_fast_backplane_clock,
    input wire [`RPBK_SYM_W-1:0] i_fast_backplane_data,
    output reg [`RPBK_SYM_W-1:0] o_fast_backplane_data,
    output reg o_fast_backplane_data_oe,
    input wire i_fast_backplane_valid_n,
    output reg o_fast_backplane_valid_n,
    output reg o_fast_backplane_valid_n_oe,
    output reg o_fast_backplane_collision,
    input wire i_fast_backplane_single_driver,
    output reg o_fast_transceiver_drive_enable_n,
    output reg o_fast_transceiver_drive_enable_n_oe,
    input wire [`RPBK_SYM_W-1:0] i_fast_tx_symbol,
    input wire i_fast_tx_valid,
    input wire i_mac_backplane_join,
    input wire i_slow_local_active,
    output reg o_slow_collision_sense_local_n,
    output reg o_slow_collision_sense_local_n_oe,
    output reg o_slow_collision_sense_stack_n,
    output reg o_slow_collision_sense_stack_n_oe,
    output reg o_slow_transceiver_drive_enable_n,
    output reg o_slow_transceiver_drive_enable_n_oe,
    input wire i_mii_speed_select,
    input wire i_mii_tx_clock,
    output reg [`RPBK_NIB_W-1:0] o_mii_tx_data,
    output reg o_mii_tx_enable,
    output reg o_mii_speed,
    output reg o_rx_ready
);
    // Rising edge of a filtered level
    function rise;
        input cur;
        input prev;
        begin
            rise = cur & ~prev;
        end
    endfunction

    reg [`RPBK_SYNC_W-1:0] sync1;
    reg [`RPBK_SYNC_W-1:0] sync2;
    reg [`RPBK_SYNC_W-1:0] sync3;
    reg [`RPBK_SYNC_W-1:0] filt;
    reg fb_clk_prev;
    reg mii_clk_prev;
    wire [`RPBK_SYNC_W-1:0] agree;
    wire [`RPBK_SYNC_W-1:0] async_in;
    wire [`RPBK_SYM_W-1:0] f_data;
    wire f_valid_n;
    wire f_fb_clk;
    wire f_single;
    wire f_mii_clk;
    wire f_join;
    wire f_speed;
    wire fb_tick;
    wire mii_tick;

    // Every pin input but i_slow_local_active, i_fast_tx_symbol and i_fast_tx_valid passes three flops; a change counts once 2 and 3 agree
    assign async_in = {i_mii_speed_select, i_mac_backplane_join,
                       i_mii_tx_clock, i_fast_backplane_single_driver,
                       i_fast_backplane_clock, i_fast_backplane_valid_n,
                       i_fast_backplane_data};
    assign agree = ~(sync2 ^ sync3);
    assign f_data = filt[`RPBK_SYM_W-1:0];
    assign f_valid_n = filt[5];
    assign f_fb_clk = filt[6];
    assign f_single = filt[7];
    assign f_mii_clk = filt[8];
    assign f_join = filt[9];
    assign f_speed = filt[10];

    always @(posedge i_clk) begin
        if (i_srst) begin
            sync1 <= {`RPBK_SYNC_W{1'b0}};
            sync2 <= {`RPBK_SYNC_W{1'b0}};
            sync3 <= {`RPBK_SYNC_W{1'b0}};
            filt <= {`RPBK_SYNC_W{1'b0}};
            fb_clk_prev <= 1'b0;
            mii_clk_prev <= 1'b0;
        end else if (i_ce) begin
            sync1 <= async_in;
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= (sync3 & agree) | (filt & ~agree);
            fb_clk_prev <= f_fb_clk;
            mii_clk_prev <= f_mii_clk;
        end
    end

    // Link clocks are sampled, not used as clocks
    assign fb_tick = rise(f_fb_clk, fb_clk_prev);
    assign mii_tick = rise(f_mii_clk, mii_clk_prev);

    // Fast backplane receive: symbols from other devices go to the FIFO
    wire rx_push;
    wire fifo_in_ready;
    wire [`RPBK_SYM_W-1:0] fifo_out;
    wire fifo_out_valid;
    reg fifo_pop;
    reg tx_drive;

    assign rx_push = fb_tick && !f_valid_n && !tx_drive;

    rpbk_fifo #(
        .WIDTH(`RPBK_SYM_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_data(f_data),
        .i_valid(rx_push),
        .o_ready(fifo_in_ready),
        .o_data(fifo_out),
        .o_valid(fifo_out_valid),
        .i_ready(fifo_pop)
    );

    // Fast backplane transmit; changes only at a link clock edge
    // so the bus stays stable for a whole link period
    always @(posedge i_clk) begin
        if (i_srst) begin
            tx_drive <= 1'b0;
            o_fast_backplane_data <= {`RPBK_SYM_W{1'b0}};
            o_fast_backplane_data_oe <= 1'b0;
            o_fast_backplane_valid_n <= 1'b0;
            o_fast_backplane_valid_n_oe <= 1'b0;
            o_fast_transceiver_drive_enable_n <= 1'b0;
            o_fast_transceiver_drive_enable_n_oe <= 1'b0;
            o_fast_backplane_collision <= 1'b0;
            o_rx_ready <= 1'b0;
        end else if (i_ce) begin
            o_rx_ready <= fifo_in_ready;
            if (fb_tick) begin
                tx_drive <= i_fast_tx_valid;
                o_fast_backplane_data <= i_fast_tx_symbol;
                o_fast_backplane_data_oe <= i_fast_tx_valid;
                o_fast_backplane_valid_n_oe <= i_fast_tx_valid;
                o_fast_transceiver_drive_enable_n_oe <= i_fast_tx_valid;
            end
            // Open-drain value stays low; only the enable moves
            o_fast_backplane_valid_n <= 1'b0;
            o_fast_transceiver_drive_enable_n <= 1'b0;
            // Another driver present while we drive means collision
            o_fast_backplane_collision <= tx_drive && !f_valid_n &&
                                          !f_single;
        end
    end

    // Slow backplane: own logic, shares only the input synchronizer with the fast side
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_slow_collision_sense_local_n <= 1'b0;
            o_slow_collision_sense_local_n_oe <= 1'b0;
            o_slow_collision_sense_stack_n <= 1'b0;
            o_slow_collision_sense_stack_n_oe <= 1'b0;
            o_slow_transceiver_drive_enable_n <= 1'b0;
            o_slow_transceiver_drive_enable_n_oe <= 1'b0;
        end else if (i_ce) begin
            o_slow_collision_sense_local_n <= 1'b0;
            o_slow_collision_sense_stack_n <= 1'b0;
            o_slow_transceiver_drive_enable_n <= 1'b0;
            o_slow_collision_sense_local_n_oe <= f_join ||
                                                i_slow_local_active;
            o_slow_collision_sense_stack_n_oe <= f_join ||
                                                i_slow_local_active;
            o_slow_transceiver_drive_enable_n_oe <= i_slow_local_active;
        end
    end

    // MII transmit framing, paced by the MAC's transmit clock
    reg [1:0] state;
    reg [3:0] cnt;

    always @(posedge i_clk) begin
        if (i_srst) begin
            state <= `RPBK_ST_IDLE;
            cnt <= 4'h0;
            fifo_pop <= 1'b0;
            o_mii_tx_data <= 4'h0;
            o_mii_tx_enable <= 1'b0;
            o_mii_speed <= 1'b0;
        end else if (i_ce) begin
            fifo_pop <= 1'b0;
            o_mii_speed <= f_speed;
            if (mii_tick && !fifo_pop) begin
                case (state)
                    `RPBK_ST_IDLE: begin
                        o_mii_tx_enable <= 1'b0;
                        cnt <= 4'h0;
                        // Speed is fixed for the frame at its start
                        if (fifo_out_valid) begin
                            if (f_speed == `RPBK_SPEED_100) begin
                                state <= `RPBK_ST_PRE;
                            end else begin
                                state <= `RPBK_ST_SFD;
                            end
                        end
                    end
                    `RPBK_ST_PRE: begin
                        o_mii_tx_enable <= 1'b1;
                        o_mii_tx_data <= `RPBK_PRE_NIB;
                        if (cnt == `RPBK_PRE_NIBBLES - 4'h1) begin
                            cnt <= 4'h0;
                            state <= `RPBK_ST_SFD;
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                    `RPBK_ST_SFD: begin
                        o_mii_tx_enable <= 1'b1;
                        if (cnt == 4'h0) begin
                            o_mii_tx_data <= `RPBK_SFD_LO;
                            cnt <= 4'h1;
                        end else begin
                            o_mii_tx_data <= `RPBK_SFD_HI;
                            cnt <= 4'h0;
                            state <= `RPBK_ST_DATA;
                        end
                    end
                    `RPBK_ST_DATA: begin
                        // An empty FIFO ends the frame
                        if (fifo_out_valid) begin
                            o_mii_tx_enable <= 1'b1;
                            o_mii_tx_data <= fifo_out[`RPBK_NIB_W-1:0];
                            fifo_pop <= 1'b1;
                        end else begin
                            o_mii_tx_enable <= 1'b0;
                            state <= `RPBK_ST_IDLE;
                        end
                    end
                    default: begin
                        state <= `RPBK_ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== rpbk_top_sva.sv
// Port checker for the repeater backplane block
`timescale 1ns/1ns
`default_nettype none
module rpbk_top_sva (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_mac_backplane_join,
    input wire logic i_slow_local_active,
    input wire logic i_mii_speed_select,
    input wire logic o_fast_backplane_valid_n,
    input wire logic o_fast_backplane_data_oe,
    input wire logic o_fast_backplane_valid_n_oe,
    input wire logic o_fast_transceiver_drive_enable_n,
    input wire logic o_fast_transceiver_drive_enable_n_oe,
    input wire logic o_slow_collision_sense_local_n_oe,
    input wire logic o_slow_collision_sense_stack_n_oe,
    input wire logic o_slow_transceiver_drive_enable_n_oe,
    input wire logic o_mii_speed,
    input wire logic o_mii_tx_enable,
    input wire logic [3:0] o_mii_tx_data
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // Join must outlast sync and filter before the lines are pulled
    sequence join_held;
        i_mac_backplane_join [*8];
    endsequence
    sequence slow_quiet;
        (!i_mac_backplane_join && !i_slow_local_active) [*8];
    endsequence
    valid_pull_low_a: assert property (o_fast_backplane_valid_n == 1'b0)
        else $error("valid line driven high");
    den_pull_low_a: assert property (!o_fast_transceiver_drive_enable_n)
        else $error("drive enable driven high");
    join_local_a: assert property (join_held |-> o_slow_collision_sense_local_n_oe)
        else $error("local sense not pulled for joined mac");
    join_stack_a: assert property (join_held |-> o_slow_collision_sense_stack_n_oe)
        else $error("stack sense not pulled for joined mac");
    quiet_sense_a: assert property (slow_quiet |-> !o_slow_collision_sense_local_n_oe)
        else $error("local sense pulled while idle");
    slow_den_a: assert property ($stable(i_slow_local_active) [*3]
        |-> o_slow_transceiver_drive_enable_n_oe == i_slow_local_active)
        else $error("slow drive enable wrong");
    fast_den_a: assert property (o_fast_transceiver_drive_enable_n_oe
        == o_fast_backplane_data_oe) else $error("fast drive enable apart");
    fast_valid_a: assert property (o_fast_backplane_valid_n_oe
        == o_fast_backplane_data_oe) else $error("valid apart from data");
    speed_follow_a: assert property ($stable(i_mii_speed_select) [*8]
        |-> ##2 o_mii_speed == $past(i_mii_speed_select, 2))
        else $error("mii speed not following select");
    sfd_first_a: assert property ($rose(o_mii_tx_enable) |-> o_mii_tx_data == 4'h5)
        else $error("frame does not open with 0x5");
endmodule
bind rpbk_top rpbk_top_sva chk_u (.*);
`default_nettype wire

// ===== rpbk_top_tb.sv
// Self-checking bench for the repeater backplane block
`timescale 1ns/1ns
`default_nettype none
module rpbk_top_tb;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_ce = 1'b1;
    logic i_fast_backplane_single_driver = 1'b1;
    logic i_fast_tx_valid = 1'b0;
    logic [4:0] i_fast_tx_symbol = 5'h00;
    logic i_mac_backplane_join = 1'b0;
    logic i_slow_local_active = 1'b0;
    logic i_mii_speed_select = 1'b1;
    logic i_mii_tx_clock = 1'b0;
    logic [4:0] o_fast_backplane_data, far_data;
    logic [3:0] o_mii_tx_data;
    logic o_fast_backplane_data_oe, o_fast_backplane_valid_n;
    logic o_fast_backplane_valid_n_oe, o_fast_transceiver_drive_enable_n;
    logic o_fast_transceiver_drive_enable_n_oe, o_slow_collision_sense_local_n_oe;
    logic o_slow_collision_sense_stack_n_oe, o_slow_transceiver_drive_enable_n_oe;
    logic o_mii_tx_enable, o_mii_speed, o_rx_ready, far_clk, far_oe, saw_full;
    logic o_fast_backplane_collision;
    logic [3:0] rxq[$];
    int error_cnt = 0;
    int comparisons = 0;
    int mii_half = 48;
    // Open-drain valid: pulled up unless some party pulls it low
    wire logic valid_wire = !(far_oe | o_fast_backplane_valid_n_oe);
    wire logic [4:0] bus = o_fast_backplane_data_oe ? o_fast_backplane_data : far_data;
    always #4 i_clk = ~i_clk;
    // Free-running MAC clock; every edge lands on a core clock edge
    always #(mii_half) i_mii_tx_clock = ~i_mii_tx_clock;
    always @(posedge i_mii_tx_clock)
        if (o_mii_tx_enable === 1'b1) rxq.push_back(o_mii_tx_data);
    always @(posedge i_clk)
        if (o_rx_ready === 1'b0) saw_full <= 1'b1;
    rpbk_top dut_u (
        .i_fast_backplane_clock(far_clk),
        .i_fast_backplane_data(bus),
        .i_fast_backplane_valid_n(valid_wire),
        .o_slow_collision_sense_local_n(),
        .o_slow_collision_sense_stack_n(),
        .o_slow_transceiver_drive_enable_n(),
        .*
    );
    rpbk_far_end far_u (.o_clk(far_clk), .o_data(far_data),
        .o_valid_n_oe(far_oe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Ends on a falling edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic t_slow(input logic j, input logic l);
        @(posedge i_clk);
        i_mac_backplane_join <= j;
        i_slow_local_active <= l;
        cyc(12);
        chk(o_slow_collision_sense_local_n_oe, j | l);
        chk(o_slow_collision_sense_stack_n_oe, j | l);
        chk(o_slow_transceiver_drive_enable_n_oe, l);
    endtask
    task automatic t_fast;
        @(posedge i_clk);
        i_fast_tx_valid <= 1'b1;
        i_fast_tx_symbol <= 5'h1A;
        i_fast_backplane_single_driver <= 1'b0;
        far_u.send(3, 5'h00, 1'b0);
        cyc(8);
        chk(o_fast_backplane_collision, 1'b1);
        chk(o_fast_transceiver_drive_enable_n_oe, 1'b1);
        chk(bus, 5'h1A);
        chk(valid_wire, 1'b0);
        chk(o_slow_collision_sense_stack_n_oe, 1'b1);
        @(posedge i_clk);
        i_fast_tx_valid <= 1'b0;
        far_u.send(2, 5'h00, 1'b0);
        cyc(8);
        chk(o_fast_backplane_data_oe, 1'b0);
        chk(valid_wire, 1'b1);
        chk(o_fast_backplane_collision, 1'b0);
        @(posedge i_clk);
        i_fast_backplane_single_driver <= 1'b1;
    endtask
    // One frame over the backplane, out on the MII; full expects refusal
    task automatic t_mii(input logic spd, input int n, input logic [4:0] base,
        input logic full);
        logic [3:0] exp[$];
        int w;
        @(posedge i_clk);
        i_mii_speed_select <= spd;
        mii_half = spd ? 48 : 200;
        cyc(20);
        chk(o_mii_speed, spd);
        rxq = {};
        saw_full = 1'b0;
        repeat (spd ? 15 : 1) exp.push_back(4'h5);
        exp.push_back(4'hD);
        for (int k = 0; k < n; k++) exp.push_back(base[3:0] + 4'(k));
        far_u.send(n, base, 1'b1);
        w = 0;
        while ((o_mii_tx_enable !== 1'b0 || w < 100) && w < 20000) begin
            cyc(1);
            w++;
        end
        chk(8'(w < 20000), 8'h01);
        chk(saw_full, full);
        if (!full) chk(8'(rxq.size()), 8'(exp.size()));
        for (int i = 0; i < (full ? 12 : exp.size()); i++) chk(rxq[i], exp[i]);
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_srst <= 1'b0;
        cyc(4);
        t_slow(1'b1, 1'b0);
        t_slow(1'b1, 1'b1);
        t_fast();
        t_slow(1'b0, 1'b1);
        t_slow(1'b0, 1'b0);
        t_mii(1'b1, 8, 5'h13, 1'b0);
        t_mii(1'b0, 8, 5'h07, 1'b0);
        t_mii(1'b0, 24, 5'h00, 1'b1);
        print_verdict();
    end
    // Whole run needs about 20 us
    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
